// ---- inc/dvm_pkg.sv ----
// package for the dac volume and mute stage: register map, fields, constants, carriers
`default_nettype none
package dvm_pkg;

    // sample carrier width
    localparam int SAMPLE_W = 16;
    // axi4-lite address width, byte address = register index * 4
    localparam int ADDR_W   = 10;

    // register indices
    localparam logic [7:0] IDX_SETUP_ONE = 8'h3f;
    localparam logic [7:0] IDX_SETUP_TWO = 8'h40;
    localparam logic [7:0] IDX_LEFT_VOL  = 8'h41;
    localparam logic [7:0] IDX_RIGHT_VOL = 8'h42;
    localparam logic [7:0] IDX_STATUS    = 8'h50;

    // reset values
    localparam logic [7:0] SETUP_ONE_RST = 8'h14;
    localparam logic [7:0] SETUP_TWO_RST = 8'h0c;
    localparam logic [7:0] VOL_RST       = 8'h00;

    // channel setup one fields
    localparam int SU1_RPWR_BIT  = 6;
    localparam int SU1_STEP_LSB  = 0;
    // channel setup two fields
    localparam int SU2_RINV_BIT  = 7;
    localparam int SU2_AMUTE_LSB = 4;
    localparam int SU2_LMUTE_BIT = 3;
    localparam int SU2_RMUTE_BIT = 2;
    localparam int SU2_GANG_LSB  = 0;
    // status fields
    localparam int STAT_AMUTE_BIT = 0;
    localparam int STAT_BUSY_BIT  = 1;
    localparam int STAT_CURL_LSB  = 8;
    localparam int STAT_CURR_LSB  = 16;

    // volume ganging codes
    localparam logic [1:0] GANG_INDEP = 2'h0;
    localparam logic [1:0] GANG_RIGHT = 2'h1;
    localparam logic [1:0] GANG_LEFT  = 2'h2;
    // soft-step codes
    localparam logic [1:0] STEP_ONE   = 2'h0;
    localparam logic [1:0] STEP_TWO   = 2'h1;
    localparam logic [1:0] STEP_OFF   = 2'h2;

    // auto-mute run length at code 001, doubled per code
    localparam int         RUN_W      = 13;
    localparam logic [RUN_W-1:0] AMUTE_BASE = 13'h0064;

    // gain: code + bias, split into octaves of 12 half-db steps
    localparam logic [7:0] VOL_BIAS   = 8'h90;
    localparam logic [7:0] VOL_OCTAVE = 8'h0c;
    localparam int         GAIN_SHIFT = 26;
    // 10^(r/40) in q14 for r = 0..11
    localparam logic [15:0] MANT [12] = '{
        16'h4000, 16'h43cb, 16'h47cf, 16'h4c10, 16'h5092, 16'h5558,
        16'h5a67, 16'h5fc2, 16'h656f, 16'h6b72, 16'h71cf, 16'h788e
    };

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic signed [SAMPLE_W-1:0] left;
        logic signed [SAMPLE_W-1:0] right;
    } dvm_stereo_t;

endpackage
`default_nettype wire

// ---- rtl/dvm_volume_mute.sv ----
// dac digital volume, soft-step, mute, auto-mute and right modulator select
//
// Function
// - powered-down right outputs zero or inverted left
// - auto-mute code sets DC run threshold
// - left mute bit mutes left, resets set
// - right mute bit mutes right, resets set
// - gang 00 keeps channel volumes independent
// - gang 01 uses right volume for both
// - gang 10 uses left volume for both
// - left volume sets left gain, resets 0dB
// - right volume sets right gain, resets 0dB
// - volume codes are half-dB two's complement
// - top code 48 gives +24dB
// - lowest code gives -63.5dB
// - soft-step per word, per two, or jump
// - right power bit gates right substitution
//
// The AXI4-Lite register port is this design's own decision.
`default_nettype none
module dvm_volume_mute
    import dvm_pkg::*;
(
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // axi4-lite write address
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic [2:0]           s_axi_awprot,
    // axi4-lite write data
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    // axi4-lite write response
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    output logic [1:0]                s_axi_bresp,
    // axi4-lite read address
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic [2:0]           s_axi_arprot,
    // axi4-lite read data
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    // input samples, one strobe per dac word clock
    input  wire logic                 in_valid,
    input  wire dvm_stereo_t          in_data,
    // modulator samples
    output logic                      out_valid,
    output dvm_stereo_t               out_data
);

    // gain by octave shift and fractional mantissa; saturates to sample range
    function automatic logic signed [SAMPLE_W-1:0] apply_gain(
        input logic signed [SAMPLE_W-1:0] s,
        input logic [7:0]                 code
    );
        logic [7:0]          e;
        logic [4:0]          q;
        logic [3:0]          r;
        logic signed [47:0]  p;
        logic signed [47:0]  hi;
        logic signed [47:0]  lo;
        e  = 8'(code + VOL_BIAS);
        q  = 5'(e / VOL_OCTAVE);
        r  = 4'(e % VOL_OCTAVE);
        p  = 48'(s) * 48'($signed({1'b0, MANT[r]}));
        p  = p <<< q;
        p  = p >>> GAIN_SHIFT;
        hi = 48'(signed'({1'b0, {(SAMPLE_W-1){1'b1}}}));
        lo = -hi - 48'sd1;
        if (p > hi) begin
            return hi[SAMPLE_W-1:0];
        end else if (p < lo) begin
            return lo[SAMPLE_W-1:0];
        end
        return p[SAMPLE_W-1:0];
    endfunction

    // registers
    logic [7:0]          setup_one_q;
    logic [7:0]          setup_two_q;
    logic [7:0]          left_vol_q;
    logic [7:0]          right_vol_q;
    // bus state
    logic                aw_hold_q;
    logic                w_hold_q;
    logic [7:0]          aw_idx_q;
    logic [31:0]         wdata_q;
    logic                wstrb0_q;
    logic                bvalid_q;
    logic [1:0]          bresp_q;
    logic                rvalid_q;
    logic [31:0]         rdata_q;
    logic [1:0]          rresp_q;
    // datapath state
    logic [7:0]          cur_vol_q [2];
    logic                phase_q;
    dvm_stereo_t         prev_q;
    logic [RUN_W-1:0]    run_q;
    logic                out_valid_q;
    dvm_stereo_t         out_data_q;

    // field decode
    wire logic [1:0]     step_mode  = setup_one_q[SU1_STEP_LSB +: 2];
    wire logic           right_pwr  = setup_one_q[SU1_RPWR_BIT];
    wire logic           right_inv  = setup_two_q[SU2_RINV_BIT];
    wire logic [2:0]     amute_code = setup_two_q[SU2_AMUTE_LSB +: 3];
    wire logic           left_mute  = setup_two_q[SU2_LMUTE_BIT];
    wire logic           right_mute = setup_two_q[SU2_RMUTE_BIT];
    wire logic [1:0]     gang       = setup_two_q[SU2_GANG_LSB +: 2];

    // target volume per channel after ganging; code 11 falls back to independent
    wire logic [7:0]     tgt_left   = (gang == GANG_RIGHT) ? right_vol_q : left_vol_q;
    wire logic [7:0]     tgt_right  = (gang == GANG_LEFT)  ? left_vol_q  : right_vol_q;
    wire logic [7:0]     tgt_vol [2];
    assign tgt_vol[0] = tgt_left;
    assign tgt_vol[1] = tgt_right;

    // one soft-step tick per word, or per second word
    wire logic           step_tick  = in_valid &&
                                      ((step_mode == STEP_ONE) ||
                                       (step_mode == STEP_TWO && phase_q));
    wire logic           step_jump  = (step_mode == STEP_OFF);

    // dc detection; the run counter saturates so long silence stays muted
    wire logic           same_samp  = (in_data == prev_q);
    wire logic [RUN_W-1:0] run_thr  = RUN_W'(AMUTE_BASE << (amute_code - 3'h1));
    wire logic           auto_mute  = (amute_code != 3'h0) && (run_q > run_thr);
    // a word that breaks the dc run passes at once, so no real audio is eaten
    wire logic           dc_cut     = auto_mute && same_samp;
    wire logic [RUN_W-1:0] run_next = !same_samp ? '0 :
                                      (&run_q) ? run_q : RUN_W'(run_q + 1'b1);

    // mutes zero the left and a powered right; a powered-down right takes the inverted left when right_inv is set, else zero
    wire logic signed [SAMPLE_W-1:0] gain_left  = apply_gain(in_data.left, cur_vol_q[0]);
    wire logic signed [SAMPLE_W-1:0] gain_right = apply_gain(in_data.right, cur_vol_q[1]);
    wire logic signed [SAMPLE_W-1:0] mod_left   =
        (left_mute || dc_cut) ? '0 : gain_left;
    wire logic signed [SAMPLE_W-1:0] mod_right_on =
        (right_mute || dc_cut) ? '0 : gain_right;
    wire logic signed [SAMPLE_W-1:0] mod_right  =
        right_pwr ? mod_right_on : (right_inv ? ~mod_left : '0);

    // axi decode; write needs both halves held and the response slot free
    wire logic           wr_fire    = aw_hold_q && w_hold_q && !bvalid_q;
    wire logic           wr_map     = (aw_idx_q == IDX_SETUP_ONE) || (aw_idx_q == IDX_SETUP_TWO) ||
                                      (aw_idx_q == IDX_LEFT_VOL)  || (aw_idx_q == IDX_RIGHT_VOL);
    wire logic           wr_en      = wr_fire && wr_map && wstrb0_q;
    wire logic [7:0]     ar_idx     = s_axi_araddr[9:2];
    wire logic           rd_fire    = s_axi_arvalid && !rvalid_q;
    wire logic           busy       = (cur_vol_q[0] != tgt_left) || (cur_vol_q[1] != tgt_right);
    wire logic [31:0]    status_w   = {8'h00, cur_vol_q[1], cur_vol_q[0], 6'h00, busy, auto_mute};
    wire logic           rd_map     = (ar_idx == IDX_SETUP_ONE) || (ar_idx == IDX_SETUP_TWO) ||
                                      (ar_idx == IDX_LEFT_VOL)  || (ar_idx == IDX_RIGHT_VOL) ||
                                      (ar_idx == IDX_STATUS);
    wire logic [31:0]    rd_mux     =
        (ar_idx == IDX_SETUP_ONE) ? {24'h000000, setup_one_q} :
        (ar_idx == IDX_SETUP_TWO) ? {24'h000000, setup_two_q} :
        (ar_idx == IDX_LEFT_VOL)  ? {24'h000000, left_vol_q}  :
        (ar_idx == IDX_RIGHT_VOL) ? {24'h000000, right_vol_q} :
        (ar_idx == IDX_STATUS)    ? status_w : 32'h00000000;

    // bus outputs
    assign s_axi_awready = !aw_hold_q;
    assign s_axi_wready  = !w_hold_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign out_valid     = out_valid_q;
    assign out_data      = out_data_q;

    // write address and data capture, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_idx_q  <= 8'h00;
            wdata_q   <= 32'h00000000;
            wstrb0_q  <= 1'b0;
        end else begin
            if (s_axi_awvalid && !aw_hold_q) begin
                aw_hold_q <= 1'b1;
                aw_idx_q  <= s_axi_awaddr[9:2];
            end else if (wr_fire) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid && !w_hold_q) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    // write response; unmapped index answers slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // register file; only byte lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            setup_one_q <= SETUP_ONE_RST;
            setup_two_q <= SETUP_TWO_RST;
            left_vol_q  <= VOL_RST;
            right_vol_q <= VOL_RST;
        end else if (wr_en) begin
            if (aw_idx_q == IDX_SETUP_ONE) setup_one_q <= wdata_q[7:0];
            if (aw_idx_q == IDX_SETUP_TWO) setup_two_q <= wdata_q[7:0];
            if (aw_idx_q == IDX_LEFT_VOL)  left_vol_q  <= wdata_q[7:0];
            if (aw_idx_q == IDX_RIGHT_VOL) right_vol_q <= wdata_q[7:0];
        end
    end

    // read channel; one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // word phase for the every-other-word step rate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_q <= 1'b0;
        end else if (in_valid) begin
            phase_q <= !phase_q;
        end
    end

    // applied volume walks toward target one half-db code per step tick, or jumps straight to it in step-off mode
    for (genvar ch = 0; ch < 2; ch++) begin : g_step
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cur_vol_q[ch] <= VOL_RST;
            end else if (step_jump) begin
                cur_vol_q[ch] <= tgt_vol[ch];
            end else if (step_tick) begin
                if ($signed(cur_vol_q[ch]) < $signed(tgt_vol[ch])) begin
                    cur_vol_q[ch] <= 8'(cur_vol_q[ch] + 8'h01);
                end else if ($signed(cur_vol_q[ch]) > $signed(tgt_vol[ch])) begin
                    cur_vol_q[ch] <= 8'(cur_vol_q[ch] - 8'h01);
                end
            end
        end
    end

    // dc run tracking over both channels together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= '0;
            run_q  <= '0;
        end else if (in_valid) begin
            prev_q <= in_data;
            run_q  <= run_next;
        end
    end

    // output stage, one cycle behind the input strobe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
        end else begin
            out_valid_q <= in_valid;
            if (in_valid) begin
                out_data_q.left  <= mod_left;
                out_data_q.right <= mod_right;
            end
        end
    end

endmodule // dvm_volume_mute
`default_nettype wire

// ---- testbench/dvm_volume_mute_properties.sv ----
// port checker for the volume and mute stage, bound to its top module
`default_nettype none
module dvm_volume_mute_props
    import dvm_pkg::*;
(
    // clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // register bus
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    // samples
    input wire logic              in_valid,
    input wire logic              out_valid,
    input wire dvm_stereo_t       out_data
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] idx_q;
    logic [7:0] dat_q;
    logic [7:0] su1_q;
    logic [7:0] su2_q;
    logic       stb_q;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // setup shadow, taken with the response so refused writes never land
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) idx_q <= s_axi_awaddr[9:2];
        if (s_axi_wvalid && s_axi_wready) dat_q <= s_axi_wdata[7:0];
        if (s_axi_wvalid && s_axi_wready) stb_q <= s_axi_wstrb[0];
        if (!aresetn) su1_q <= SETUP_ONE_RST;
        else if ($rose(s_axi_bvalid) && s_axi_bresp == RESP_OKAY && stb_q && idx_q == IDX_SETUP_ONE)
            su1_q <= dat_q;
        if (!aresetn) su2_q <= SETUP_TWO_RST;
        else if ($rose(s_axi_bvalid) && s_axi_bresp == RESP_OKAY && stb_q && idx_q == IDX_SETUP_TWO)
            su2_q <= dat_q;
    end

    pulse_out_a: assert property (in_valid |=> out_valid)
        else $error("no output word after input word");
    hold_out_a: assert property (!in_valid |=> !out_valid && $stable(out_data))
        else $error("output moved without input word");
    left_mute_a: assert property (out_valid && su2_q[SU2_LMUTE_BIT] |-> out_data.left == '0)
        else $error("left not zero while muted");
    right_mute_a: assert property (out_valid && su2_q[SU2_RMUTE_BIT] && su1_q[SU1_RPWR_BIT]
        |-> out_data.right == '0) else $error("right not zero while muted");
    right_zero_a: assert property (out_valid && !su1_q[SU1_RPWR_BIT] && !su2_q[SU2_RINV_BIT]
        |-> out_data.right == '0) else $error("powered-down right not zero");
    right_inv_a: assert property (out_valid && !su1_q[SU1_RPWR_BIT] && su2_q[SU2_RINV_BIT]
        |-> out_data.right == ~out_data.left) else $error("right not inverted left");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write response late");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not released");
endmodule // dvm_volume_mute_props

bind dvm_volume_mute dvm_volume_mute_props u_props (.*);
`default_nettype wire

// ---- testbench/dvm_sample_source.sv ----
// sample source standing in for the audio data path
`default_nettype none
module dvm_sample_source
    import dvm_pkg::*;
(
    // clock
    input wire logic        aclk,
    // sample stream
    output var logic        in_valid,
    output var dvm_stereo_t in_data
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle with the strobe low from time zero
    initial begin
        in_valid = 1'b0;
        in_data  = '0;
    end

    // one word per strobe; between strobes the word is unqualified, so show its inverse
    task automatic send(input dvm_stereo_t s);
        @(posedge aclk);
        in_valid <= 1'b1;
        in_data  <= s;
        @(posedge aclk);
        in_valid <= 1'b0;
        in_data  <= ~s;
    endtask
endmodule // dvm_sample_source
`default_nettype wire

// ---- testbench/tb_dvm_volume_mute.sv ----
// self-checking bench for the volume and mute stage
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        num_checks++; \
        if ((g) !== (e)) begin \
            errors++; \
            $display("mismatch %s expected %h seen %h", nm, e, g); \
        end \
    end
module tb_dvm_volume_mute
    import dvm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [9:0] A_SU1 = {IDX_SETUP_ONE, 2'b00};
    localparam logic [9:0] A_SU2 = {IDX_SETUP_TWO, 2'b00};
    localparam logic [9:0] A_LV  = {IDX_LEFT_VOL, 2'b00};
    localparam logic [9:0] A_RV  = {IDX_RIGHT_VOL, 2'b00};
    localparam logic [9:0] A_ST  = {IDX_STATUS, 2'b00};
    localparam logic [9:0] A_BAD = 10'h0f8;
    // codes 0, +6, -6, +24, -12 dB and the expected left word for input -0x100
    localparam logic [7:0]  VC [5] = '{8'h00, 8'h0c, 8'hf4, 8'h30, 8'he8};
    localparam logic [15:0] VE [5] = '{16'hff00, 16'hfe00, 16'hff80, 16'hf000, 16'hffc0};

    logic              aclk = 1'b0, aresetn = 1'b0;
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0]        s_axi_awprot = '0, s_axi_arprot = '0;
    logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]        s_axi_wstrb = '0;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic              s_axi_rvalid, in_valid, out_valid;
    dvm_stereo_t       in_data, out_data;
    int                errors = 0, num_checks = 0;

    // design and the source feeding it
    dvm_volume_mute u_dut (.*);
    dvm_sample_source u_src (.aclk(aclk), .in_valid(in_valid), .in_data(in_data));

    // 100 ns clock
    initial forever #50 aclk = ~aclk;

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // a wait that ran out ends the run
    task automatic guard(input int n);
        if (n >= 40) begin
            errors++;
            close_out();
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d, output logic [1:0] resp);
        int   n = 0;
        logic aw_ok = 1'b0;
        logic w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= {24'h0, d};
        s_axi_wstrb   <= 4'hf;
        s_axi_bready  <= 1'b1;
        while (!(aw_ok && w_ok) && n < 40) begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) aw_ok = 1'b1;
            if (s_axi_wready) w_ok = 1'b1;
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 40) begin
            @(posedge aclk);
            n++;
        end
        guard(n);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n = 0;
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (!s_axi_arready && n < 40);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (!s_axi_rvalid && n < 40);
        guard(n);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // one word through the stage, answer taken at its out_valid
    task automatic smp(input logic [15:0] l, input logic [15:0] r, output dvm_stereo_t o);
        int n = 0;
        u_src.send({l, r});
        do begin
            @(posedge aclk);
            n++;
        end while (!out_valid && n < 40);
        guard(n);
        o = out_data;
    endtask

    initial begin
        dvm_stereo_t o;
        logic [31:0] d;
        logic [1:0]  rs;
        int          t;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values, muted output, unmapped place
        rd(A_SU2, d, rs);
        `CHK("setup_two", 32'h0000000c, d)
        rd(A_LV, d, rs);
        `CHK("left volume", 32'h0, d)
        rd(A_RV, d, rs);
        `CHK("right volume", 32'h0, d)
        smp(16'h1000, 16'h1000, o);
        `CHK("muted word", 32'h0, o)
        wr(A_BAD, 8'h55, rs);
        `CHK("unmapped bresp", RESP_SLVERR, rs)
        rd(A_BAD, d, rs);
        `CHK("unmapped read", {RESP_SLVERR, 32'h0}, {rs, d})
        // gain table with the right kept at 0 dB, jump mode
        wr(A_SU1, 8'h42, rs);
        `CHK("write bresp", RESP_OKAY, rs)
        wr(A_SU2, 8'h00, rs);
        for (int i = 0; i < 5; i++) begin
            wr(A_LV, VC[i], rs);
            smp(16'hff00, 16'h0100, o);
            `CHK("gain", {VE[i], 16'h0100}, o)
        end
        wr(A_LV, 8'h81, rs);
        smp(16'h7fff, 16'h0100, o);
        `CHK("lowest gain", 1'b1, o.left > 16'sd17 && o.left < 16'sd26)
        // ganging both ways
        wr(A_LV, 8'h30, rs);
        wr(A_RV, 8'hf4, rs);
        wr(A_SU2, {6'h0, GANG_RIGHT}, rs);
        smp(16'h0100, 16'h0100, o);
        `CHK("gang right", 32'h00800080, o)
        wr(A_SU2, {6'h0, GANG_LEFT}, rs);
        smp(16'h0100, 16'h0100, o);
        `CHK("gang left", 32'h10001000, o)
        // manual mutes, then right powered down
        wr(A_SU2, 8'h08, rs);
        smp(16'h0100, 16'h0100, o);
        `CHK("left mute", 32'h00000080, o)
        wr(A_SU2, 8'h04, rs);
        smp(16'h0100, 16'h0100, o);
        `CHK("right mute", 32'h10000000, o)
        wr(A_SU1, 8'h02, rs);
        wr(A_SU2, 8'h80, rs);
        smp(16'h0100, 16'h1234, o);
        `CHK("right inverted", 32'h1000efff, o)
        wr(A_SU2, 8'h00, rs);
        smp(16'h0100, 16'h1234, o);
        `CHK("right zero", 32'h10000000, o)
        // soft-step per word, per two words, then a jump
        wr(A_SU1, 8'h40, rs);
        wr(A_LV, 8'h2c, rs);
        repeat (2) smp(16'h0100, 16'h0100, o);
        rd(A_ST, d, rs);
        `CHK("step per word", 32'h00f42e02, d)
        wr(A_SU1, 8'h41, rs);
        wr(A_LV, 8'h20, rs);
        repeat (4) smp(16'h0100, 16'h0100, o);
        rd(A_ST, d, rs);
        `CHK("step per two", 32'h00f42c02, d)
        wr(A_SU1, 8'h42, rs);
        rd(A_ST, d, rs);
        `CHK("jump", 32'h00f42000, d)
        // auto-mute at every code: T+2 equal words pass, the next is cut unless the code is 0
        wr(A_LV, 8'h00, rs);
        wr(A_RV, 8'h00, rs);
        for (int c = 0; c < 8; c++) begin
            t = (c == 0) ? 200 : 100 << (c - 1);
            wr(A_SU2, {1'b0, c[2:0], 4'h0}, rs);
            smp(16'h0001, 16'h0001, o);
            `CHK("release first", 32'h00010001, o)
            smp(16'h0002, 16'h0002, o);
            `CHK("release", 32'h00020002, o)
            repeat (t + 2) smp(16'h0400, 16'h0400, o);
            `CHK("dc run", 32'h04000400, o)
            smp(16'h0400, 16'h0400, o);
            `CHK("dc cut", (c == 0) ? 32'h04000400 : 32'h0, o)
            rd(A_ST, d, rs);
            `CHK("auto flag", c != 0, d[0])
        end
        // mid-run reset brings back the reset values
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_SU2, d, rs);
        `CHK("setup_two again", {RESP_OKAY, 32'h0000000c}, {rs, d})
        rd(A_ST, d, rs);
        `CHK("status again", 32'h0, d)
        close_out();
    end
endmodule // tb_dvm_volume_mute
`default_nettype wire
